// [tprc_pkg.sv]
package tprc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] idx_plm0 = 6'h26;
  localparam logic [5:0] idx_plm1 = 6'h27;
  localparam logic [5:0] idx_plm2 = 6'h28;
  localparam logic [5:0] idx_rc0  = 6'h29;
  localparam logic [5:0] idx_offl = 6'h2a;
  localparam logic [5:0] idx_cfg  = 6'h2b;
  localparam logic [5:0] idx_stat = 6'h2c;

  localparam logic [7:0] plm0_rst = 8'h7b;
  localparam logic [7:0] plm1_rst = 8'h03;
  localparam logic [7:0] plm2_rst = 8'h40;
  localparam logic [7:0] plm2_msk = 8'h6f;
  localparam logic [7:0] rc0_rst  = 8'h00;
  localparam logic [7:0] offl_rst = 8'h00;
  localparam logic [7:0] cfg_rst  = 8'h00;

  // Receive control zero fields
  localparam int rc0_auto_crc = 0;
  localparam int rc0_forced   = 1;
  localparam int rc0_sense    = 2;
  localparam int rc0_ramode   = 3;
  localparam int rc0_up_lsb   = 4;
  localparam logic [7:0] rc0_msk = 8'h7f;

  // Configuration fields
  localparam int cfg_cmi     = 3;
  localparam int cfg_mf_lsb  = 4;
  localparam logic [7:0] cfg_msk = 8'h3f;
  localparam logic [2:0] pfc_sync   = 3'h0;
  localparam logic [2:0] pfc_marker = 3'h1;

  // Status fields
  localparam int st_alarm = 0;
  localparam int st_crc   = 1;
  localparam int st_ovf   = 2;
  localparam int st_fifo  = 3;

  localparam int tx_tri_bit  = 6;
  localparam int tx_dis_bit  = 5;
  localparam logic [1:0] release_count = 2'h3;

  typedef enum logic [1:0] {mf_f4, mf_f12, mf_esf, mf_f72} tprc_mf_t;
  typedef enum logic [2:0] {sp_idle, sp_1, sp_2, sp_3, sp_4} tprc_sp_t;

endpackage : tprc_pkg

// [tprc_fifo.sv]
`timescale 1ns/1ns
module tprc_fifo #(
  parameter int width = 2,
  parameter int depth = 4
) (
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [width-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [width-1:0]      out_data_out
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wr_ptr_reg;
  logic [aw-1:0]    rd_ptr_reg;
  logic [aw:0]      count_reg;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (count_reg != (aw+1)'(depth));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];

  always_ff @(posedge clock_in) begin
    if (push) mem[wr_ptr_reg] <= in_data_in;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == aw'(depth-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == aw'(depth-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (aw+1)'(push) - (aw+1)'(pop);
    end
  end
endmodule : tprc_fifo

// [tprc_top.sv]
// Overview of operation
// - With bit-2 detection selected, the alarm clears after three frames in a row without the all-channel bit-2-zero condition.
// - In the 12-frame format the alarm clears after three multiframes in a row without the signalling-bit alarm.
// - In extended superframe the alarm clears after the data-link alarm pattern is missed three times in a row.
// - With automatic inversion on, a CRC error inverts all CRC bits of the next outgoing multiframe, or of the next two if it comes with a multiframe start.
// - Automatic and forced CRC inversion are ORed, either one inverts the transmitted CRC bits.
// - While forced inversion is set, outgoing CRC bits are inverted before transmission.
// - Dual-rail inputs are active low when the sense bit is 0 and active high when it is 1.
// - The coded CMI input is active high when the sense bit is 0 and active low when it is 1.
// - The upper offset field gives bits 10 to 8 of the offset, and software never selects sync input and marker output together.
// - Port function 000 loads the offset into the receive bit counter while the sync pulse is active.
// - Port function 001 outputs a frame marker when the bit counter reaches the programmed position.
// - Each transmit pulse is four sub-pulses, whose 5-bit levels go out first to fourth.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
module tprc_top
  import tprc_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rstn_in,
  // Avalon-MM slave, byte addresses
  input  wire logic [7:0] avs_address_in,
  input  wire logic       avs_read_in,
  input  wire logic       avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]     avs_readdata_out,
  output logic            avs_waitrequest_out,
  // Receive line pins
  input  wire logic       rx_positive_rail_in,
  input  wire logic       rx_negative_rail_in,
  input  wire logic       rx_coded_data_in,
  input  wire logic       rx_sync_pulse_n_in,
  output logic            rx_frame_marker_out,
  output logic [10:0]     rx_bit_count_out,
  // Sensed receive data towards the framer
  output logic [1:0]      rx_data_out,
  output logic            rx_data_valid_out,
  input  wire logic       rx_data_ready_in,
  // Remote alarm events from the framer
  input  wire logic       remote_alarm_set_in,
  input  wire logic       frame_end_in,
  input  wire logic       bit2_zero_in,
  input  wire logic       multiframe_end_in,
  input  wire logic       fs_alarm_in,
  input  wire logic       dl_check_in,
  input  wire logic       dl_pattern_in,
  output logic            remote_alarm_out,
  // Transmit CRC path
  input  wire logic       crc_error_in,
  input  wire logic       tx_multiframe_start_in,
  input  wire logic       tx_crc_valid_in,
  input  wire logic       tx_crc_bit_in,
  output logic            tx_crc_valid_out,
  output logic            tx_crc_bit_out,
  // Transmit pulse shaping
  input  wire logic       tx_pulse_start_in,
  input  wire logic       subpulse_tick_in,
  output logic [4:0]      tx_level_out,
  output logic            tx_level_valid_out,
  output logic            tx_line_tristate_out,
  output logic            tx_tristate_auto_disable_out
);

  function automatic logic sense(input logic pin, input logic active_high);
    sense = active_high ? pin : ~pin;
  endfunction : sense

  // Reset release
  logic rst_meta_reg;
  logic rstn_reg;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rstn_reg     <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rstn_reg     <= rst_meta_reg;
    end
  end

  // Pin synchronisers
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  wire  [3:0] pin_raw = {rx_sync_pulse_n_in, rx_coded_data_in,
                         rx_negative_rail_in, rx_positive_rail_in};
  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      pin_meta_reg <= 4'hf;
      pin_sync_reg <= 4'hf;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Registers
  logic [7:0] plm0_reg;
  logic [7:0] plm1_reg;
  logic [7:0] plm2_reg;
  logic [7:0] rc0_reg;
  logic [7:0] offl_reg;
  logic [7:0] cfg_reg;
  logic       ovf_reg;
  logic       wait_reg;
  logic [31:0] rdata_reg;

  wire [5:0] idx      = avs_address_in[7:2];
  wire       req      = avs_read_in || avs_write_in;
  wire       wr_do    = avs_write_in && !wait_reg;
  wire [7:0] wdata    = avs_writedata_in[7:0];
  wire       wr_plm0  = wr_do && (idx == idx_plm0);
  wire       wr_plm1  = wr_do && (idx == idx_plm1);
  wire       wr_plm2  = wr_do && (idx == idx_plm2);
  wire       wr_rc0   = wr_do && (idx == idx_rc0);
  wire       wr_offl  = wr_do && (idx == idx_offl);
  wire       wr_cfg   = wr_do && (idx == idx_cfg);
  wire       wr_stat  = wr_do && (idx == idx_stat);

  // Control fields
  wire       auto_crc_invert          = rc0_reg[rc0_auto_crc];
  wire       forced_tx_crc_invert     = rc0_reg[rc0_forced];
  wire       rx_input_sense           = rc0_reg[rc0_sense];
  wire       remote_alarm_mode_select = rc0_reg[rc0_ramode];
  wire [2:0] rx_offset_upper          = rc0_reg[rc0_up_lsb +: 3];
  wire [10:0] rx_offset_value         = {rx_offset_upper, offl_reg};
  wire [2:0] rx_port_function_code    = cfg_reg[2:0];
  wire       cmi_mode                 = cfg_reg[cfg_cmi];
  tprc_mf_t  mf_format;
  assign mf_format = tprc_mf_t'(cfg_reg[cfg_mf_lsb +: 2]);

  // Sub-pulse levels span the three mask registers
  wire [4:0] first_subpulse_level  = plm0_reg[4:0];
  wire [4:0] second_subpulse_level = {plm1_reg[1:0], plm0_reg[7:5]};
  wire [4:0] third_subpulse_level  = plm1_reg[6:2];
  wire [4:0] fourth_subpulse_level = {plm2_reg[3:0], plm1_reg[7]};

  logic [7:0] status;
  wire  fifo_in_ready;
  wire  fifo_out_valid;
  logic crc_active_reg;

  always_comb begin
    status           = 8'h00;
    status[st_alarm] = remote_alarm_out;
    status[st_crc]   = crc_active_reg;
    status[st_ovf]   = ovf_reg;
    status[st_fifo]  = fifo_out_valid;
  end

  logic [7:0] rd_mux;
  always_comb begin
    unique case (idx)
      idx_plm0: rd_mux = plm0_reg;
      idx_plm1: rd_mux = plm1_reg;
      idx_plm2: rd_mux = plm2_reg;
      idx_rc0:  rd_mux = rc0_reg;
      idx_offl: rd_mux = offl_reg;
      idx_cfg:  rd_mux = cfg_reg;
      idx_stat: rd_mux = status;
      default:  rd_mux = 8'h00;
    endcase
  end

  // One wait cycle: capture, then waitrequest low for one edge
  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (req && wait_reg) begin
      wait_reg  <= 1'b0;
      rdata_reg <= {24'h00_0000, rd_mux};
    end else begin
      wait_reg  <= 1'b1;
    end
  end
  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out    = rdata_reg;

  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      plm0_reg <= plm0_rst;
      plm1_reg <= plm1_rst;
      plm2_reg <= plm2_rst;
      rc0_reg  <= rc0_rst;
      offl_reg <= offl_rst;
      cfg_reg  <= cfg_rst;
    end else begin
      if (wr_plm0) plm0_reg <= wdata;
      if (wr_plm1) plm1_reg <= wdata;
      if (wr_plm2) plm2_reg <= wdata & plm2_msk;
      if (wr_rc0) rc0_reg <= wdata & rc0_msk;
      if (wr_offl) offl_reg <= wdata;
      if (wr_cfg) cfg_reg <= wdata & cfg_msk;
    end
  end

  // Rails and coded input have opposite senses
  wire pos_sensed   = sense(pin_sync_reg[0], rx_input_sense);
  wire neg_sensed   = sense(pin_sync_reg[1], rx_input_sense);
  wire coded_sensed = sense(pin_sync_reg[2], !rx_input_sense);
  wire sync_active  = !pin_sync_reg[3];
  wire [1:0] rx_word = cmi_mode ? {coded_sensed, 1'b0} : {pos_sensed, neg_sensed};

  // Line data cannot stall, so a full buffer drops the bit and flags it
  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      ovf_reg <= 1'b0;
    end else if (!fifo_in_ready) begin
      ovf_reg <= 1'b1;
    end else if (wr_stat && wdata[st_ovf]) begin
      ovf_reg <= 1'b0;
    end
  end

  wire [1:0] fifo_data;
  wire       take_out = !rx_data_valid_out || rx_data_ready_in;
  tprc_fifo #(
    .width (2),
    .depth (4)
  ) u_fifo (
    .clock_in      (clock_in),
    .rstn_in       (rstn_reg),
    .in_valid_in   (1'b1),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (rx_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (take_out),
    .out_data_out  (fifo_data)
  );

  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      rx_data_valid_out <= 1'b0;
      rx_data_out       <= 2'h0;
    end else if (take_out) begin
      rx_data_valid_out <= fifo_out_valid;
      rx_data_out       <= fifo_data;
    end
  end

  // Receive bit counter, offset load and frame marker
  logic [10:0] bit_count_reg;
  wire load_offset = (rx_port_function_code == pfc_sync) && sync_active;
  wire marker_hit  = (rx_port_function_code == pfc_marker)
                     && (bit_count_reg == rx_offset_value);
  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      bit_count_reg       <= 11'h000;
      rx_frame_marker_out <= 1'b0;
    end else begin
      bit_count_reg       <= load_offset ? rx_offset_value
                                         : bit_count_reg + 11'h001;
      rx_frame_marker_out <= marker_hit;
    end
  end
  assign rx_bit_count_out = bit_count_reg;

  // Remote alarm release
  logic [1:0] absent_count_reg;
  logic       rel_event;
  logic       rel_absent;
  always_comb begin
    rel_event  = frame_end_in;
    rel_absent = !bit2_zero_in;
    if (!remote_alarm_mode_select) begin
      unique case (mf_format)
        mf_f12: begin
          rel_event  = multiframe_end_in;
          rel_absent = !fs_alarm_in;
        end
        mf_esf: begin
          rel_event  = dl_check_in;
          rel_absent = !dl_pattern_in;
        end
        mf_f4, mf_f72: begin
          rel_event  = frame_end_in;
          rel_absent = !bit2_zero_in;
        end
      endcase
    end
  end

  wire release_now = rel_event && rel_absent && (absent_count_reg == release_count - 2'h1);
  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      remote_alarm_out <= 1'b0;
      absent_count_reg <= 2'h0;
    end else if (remote_alarm_set_in) begin
      remote_alarm_out <= 1'b1;
      absent_count_reg <= 2'h0;
    end else if (remote_alarm_out && rel_event) begin
      if (!rel_absent) begin
        absent_count_reg <= 2'h0;
      end else if (release_now) begin
        remote_alarm_out <= 1'b0;
        absent_count_reg <= 2'h0;
      end else begin
        absent_count_reg <= absent_count_reg + 2'h1;
      end
    end
  end

  // CRC inversion: an error arms the next outgoing multiframe, or the next two if it comes with a multiframe start
  logic crc_pending_reg;
  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      crc_pending_reg <= 1'b0;
      crc_active_reg  <= 1'b0;
    end else begin
      if (tx_multiframe_start_in) begin
        crc_active_reg <= auto_crc_invert && (crc_pending_reg || crc_error_in);
      end
      if (crc_error_in) begin
        crc_pending_reg <= 1'b1;
      end else if (tx_multiframe_start_in) begin
        crc_pending_reg <= 1'b0;
      end
    end
  end

  wire crc_invert = forced_tx_crc_invert || (auto_crc_invert && crc_active_reg);
  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      tx_crc_valid_out <= 1'b0;
      tx_crc_bit_out   <= 1'b0;
    end else begin
      tx_crc_valid_out <= tx_crc_valid_in;
      tx_crc_bit_out   <= tx_crc_bit_in ^ crc_invert;
    end
  end

  // Sub-pulse sequencer
  tprc_sp_t sp_reg;
  tprc_sp_t sp_next;
  always_comb begin
    sp_next = sp_reg;
    unique case (sp_reg)
      sp_idle: if (tx_pulse_start_in) sp_next = sp_1;
      sp_1:    if (subpulse_tick_in) sp_next = sp_2;
      sp_2:    if (subpulse_tick_in) sp_next = sp_3;
      sp_3:    if (subpulse_tick_in) sp_next = sp_4;
      sp_4:    if (subpulse_tick_in) sp_next = sp_idle;
      default: sp_next = sp_idle;
    endcase
  end

  logic [4:0] level_sel;
  always_comb begin
    unique case (sp_next)
      sp_1:    level_sel = first_subpulse_level;
      sp_2:    level_sel = second_subpulse_level;
      sp_3:    level_sel = third_subpulse_level;
      sp_4:    level_sel = fourth_subpulse_level;
      default: level_sel = 5'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      sp_reg                       <= sp_idle;
      tx_level_out                 <= 5'h00;
      tx_level_valid_out           <= 1'b0;
      tx_line_tristate_out         <= 1'b0;
      tx_tristate_auto_disable_out <= 1'b0;
    end else begin
      sp_reg                       <= sp_next;
      tx_level_out                 <= level_sel;
      tx_level_valid_out           <= (sp_next != sp_idle);
      tx_line_tristate_out         <= plm2_reg[tx_tri_bit];
      tx_tristate_auto_disable_out <= plm2_reg[tx_dis_bit];
    end
  end

endmodule : tprc_top

// [tprc_checker.sv]
`timescale 1ns/1ns
module tprc_checker
  import tprc_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        rx_frame_marker_out,
  input wire logic [10:0] rx_bit_count_out,
  input wire logic        remote_alarm_set_in,
  input wire logic        frame_end_in,
  input wire logic        multiframe_end_in,
  input wire logic        dl_check_in,
  input wire logic        remote_alarm_out,
  input wire logic        tx_crc_valid_in,
  input wire logic        tx_crc_bit_in,
  input wire logic        tx_crc_valid_out,
  input wire logic        tx_crc_bit_out,
  input wire logic        tx_pulse_start_in,
  input wire logic [4:0]  tx_level_out,
  input wire logic        tx_level_valid_out
);
  logic [7:0]  rc0_reg;
  logic [7:0]  offl_reg;
  logic [7:0]  cfg_reg;
  logic [7:0]  plm0_reg;
  wire         wr_hit  = avs_write_in && !avs_waitrequest_out;
  wire  [5:0]  wr_idx  = avs_address_in[7:2];
  wire  [10:0] offset  = {rc0_reg[6:4], offl_reg};
  wire         hit_now = cfg_reg[2:0] == pfc_marker && rx_bit_count_out == offset;
  wire         any_evt = frame_end_in || multiframe_end_in || dl_check_in || remote_alarm_set_in;

  // Shadows follow accepted writes, so no internals are probed
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rc0_reg  <= rc0_rst;
      offl_reg <= offl_rst;
      cfg_reg  <= cfg_rst;
      plm0_reg <= plm0_rst;
    end else if (wr_hit) begin
      if (wr_idx == idx_rc0) rc0_reg <= avs_writedata_in[7:0] & rc0_msk;
      if (wr_idx == idx_offl) offl_reg <= avs_writedata_in[7:0];
      if (wr_idx == idx_cfg) cfg_reg <= avs_writedata_in[7:0] & cfg_msk;
      if (wr_idx == idx_plm0) plm0_reg <= avs_writedata_in[7:0];
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low over one cycle");
  answer_next_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered next cycle");
  rc0_readback_a: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in[7:2] == idx_rc0 |-> avs_readdata_out == {24'h0, rc0_reg})
    else $error("rc0 read-back differs from last write");
  crc_valid_a: assert property (tx_crc_valid_out == $past(tx_crc_valid_in))
    else $error("crc strobe not delayed");
  crc_forced_a: assert property (tx_crc_valid_in && rc0_reg[rc0_forced]
    |=> tx_crc_bit_out != $past(tx_crc_bit_in)) else $error("forced crc bit not inverted");
  crc_plain_a: assert property (tx_crc_valid_in && rc0_reg[1:0] == 2'h0
    |=> tx_crc_bit_out == $past(tx_crc_bit_in)) else $error("crc bit inverted when off");
  marker_hit_a: assert property (rx_frame_marker_out == $past(hit_now))
    else $error("marker not one cycle after match");
  count_step_a: assert property (cfg_reg[2:0] != pfc_sync
    |=> rx_bit_count_out == $past(rx_bit_count_out) + 11'h1) else $error("bit counter skipped");
  alarm_set_a: assert property (remote_alarm_set_in |=> remote_alarm_out)
    else $error("remote alarm not set");
  alarm_hold_a: assert property (!any_evt |=> $stable(remote_alarm_out))
    else $error("alarm changed without event");
  first_level_a: assert property (tx_pulse_start_in && !tx_level_valid_out
    |=> tx_level_valid_out && tx_level_out == plm0_reg[4:0])
    else $error("first sub-pulse level wrong");
endmodule : tprc_checker

bind tprc_top tprc_checker u_checker (
  .clock_in, .rstn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_readdata_out, .avs_waitrequest_out, .rx_frame_marker_out, .rx_bit_count_out,
  .remote_alarm_set_in, .frame_end_in, .multiframe_end_in, .dl_check_in, .remote_alarm_out,
  .tx_crc_valid_in, .tx_crc_bit_in, .tx_crc_valid_out, .tx_crc_bit_out, .tx_pulse_start_in,
  .tx_level_out, .tx_level_valid_out
);

// [tprc_line_model.sv]
`timescale 1ns/1ns
module tprc_line_model (
  input  wire logic       clock_in,
  input  wire logic [2:0] pins_in,
  input  wire logic       sync_in,
  input  wire logic       hold_in,
  input  wire logic       slow_in,
  output logic [2:0]      line_out,
  output logic            sync_n_out,
  output logic            ready_out
);
  int          seed = 52;
  logic [31:0] rnd;

  initial ready_out = 1'b1;
  // Line pins are always driven
  assign line_out   = pins_in;
  assign sync_n_out = !sync_in;
  // Slow mode drops ready at random
  always @(posedge clock_in) begin
    rnd = $random(seed);
    ready_out <= !hold_in && !(slow_in && rnd[0]);
  end
endmodule : tprc_line_model

// [t1_receive_control_and_pulse_mask_tb.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module t1_receive_control_and_pulse_mask_tb;
  import tprc_pkg::*;
  localparam int         ratio = 1;
  localparam logic [5:0] ridx [6] = '{idx_plm0, idx_plm1, idx_plm2, idx_rc0, idx_offl, idx_cfg};
  localparam logic [7:0] rrst [6] = '{plm0_rst, plm1_rst, plm2_rst, rc0_rst, offl_rst, cfg_rst};
  localparam logic [7:0] rmsk [6] = '{8'hff, 8'hff, plm2_msk, rc0_msk, 8'hff, cfg_msk};
  localparam logic [7:0] acfg [3] = '{8'h22, 8'h12, 8'h22};
  logic        clock_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0]  ev = 8'h00;
  logic [2:0]  cond = 3'h0;
  logic [2:0]  pins = 3'h0;
  logic        crc_v = 1'b0;
  logic        crc_b = 1'b0;
  logic        sync = 1'b0;
  logic        hold = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] rdata, r, rnd;
  logic        wreq, marker, rxv, alarm, crc_vo, crc_bo, lvlv, tri_o, dis_o, ready, sync_n;
  logic [10:0] count, off;
  logic [1:0]  rxd;
  logic [4:0]  lvl;
  logic [2:0]  line;
  logic [4:0]  lv [4];
  int          err_count = 0;
  int          tests_run = 0;
  int          seed = 52;
  int          cycles = 0;
  int          mp, n;

  tprc_top DUT (.clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .rx_positive_rail_in(line[2]), .rx_negative_rail_in(line[1]),
    .rx_coded_data_in(line[0]), .rx_sync_pulse_n_in(sync_n), .rx_frame_marker_out(marker),
    .rx_bit_count_out(count), .rx_data_out(rxd), .rx_data_valid_out(rxv),
    .rx_data_ready_in(ready), .remote_alarm_set_in(ev[0]), .frame_end_in(ev[1]),
    .bit2_zero_in(cond[0]), .multiframe_end_in(ev[2]), .fs_alarm_in(cond[1]),
    .dl_check_in(ev[3]), .dl_pattern_in(cond[2]), .remote_alarm_out(alarm),
    .crc_error_in(ev[4]), .tx_multiframe_start_in(ev[5]), .tx_crc_valid_in(crc_v),
    .tx_crc_bit_in(crc_b), .tx_crc_valid_out(crc_vo), .tx_crc_bit_out(crc_bo),
    .tx_pulse_start_in(ev[6]), .subpulse_tick_in(ev[7]), .tx_level_out(lvl),
    .tx_level_valid_out(lvlv), .tx_line_tristate_out(tri_o),
    .tx_tristate_auto_disable_out(dis_o));
  tprc_line_model LINE (.clock_in(clock_in), .pins_in(pins), .sync_in(sync), .hold_in(hold),
    .slow_in(slow), .line_out(line), .sync_n_out(sync_n), .ready_out(ready));

  initial begin
    forever #2 clock_in = ~clock_in;
  end

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clock_in);
    addr  <= {idx, 2'h0};
    wr    <= w;
    rd    <= !w;
    wdata <= {24'h0, d};
    do @(posedge clock_in); while (wreq !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clock_in);
    ev[b] <= 1'b0;
    @(posedge clock_in);
  endtask : pulse

  task automatic crc_chk(input logic inv);
    rnd = $random(seed);
    crc_v <= 1'b1;
    crc_b <= rnd[0];
    @(posedge clock_in);
    crc_v <= 1'b0;
    @(posedge clock_in);
    `CHK({crc_vo, crc_bo}, {1'b1, rnd[0] ^ inv})
  endtask : crc_chk

  function automatic logic [1:0] sense(input logic cmi, input logic s, input logic [2:0] p);
    if (cmi) return {p[0] ^ s, 1'b0};
    return s ? p[2:1] : ~p[2:1];
  endfunction : sense

  // Offset that software programs for a position
  function automatic logic [10:0] mp_off(input logic t1, input int mp);
    if (t1) return 11'(mp <= 193 * ratio - 3 ? mp + 2 + 7 * ratio : mp + 2 - 186 * ratio);
    return 11'(mp <= 2045 ? mp + 2 : mp - 2046);
  endfunction : mp_off

  initial begin
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ridx[i], 8'h00);
      `CHK(r, {24'h0, rrst[i]})
    end
    for (int i = 0; i < 7; i++) begin
      rnd = $random(seed);
      bus(1'b1, i < 6 ? ridx[i] : 6'h3f, rnd[7:0]);
      bus(1'b0, i < 6 ? ridx[i] : 6'h3f, 8'h00);
      `CHK(r, i < 6 ? {24'h0, rnd[7:0] & rmsk[i]} : 32'h0)
      if (i == 2) `CHK({tri_o, dis_o}, rnd[6:5])
    end
    $display("Test done: registers");
    for (int k = 0; k < 4; k++) begin
      rnd = $random(seed);
      lv[k] = rnd[4:0];
    end
    bus(1'b1, idx_plm0, {lv[1][2:0], lv[0]});
    bus(1'b1, idx_plm1, {lv[3][0], lv[2], lv[1][4:3]});
    bus(1'b1, idx_plm2, {4'h0, lv[3][4:1]});
    pulse(6);
    for (int k = 0; k < 4; k++) begin
      `CHK({lvlv, lvl}, {1'b1, lv[k]})
      pulse(7);
    end
    `CHK(lvlv, 1'b0)
    $display("Test done: sub-pulses");
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, idx_cfg, acfg[c]);
      bus(1'b1, idx_rc0, c == 0 ? 8'h08 : 8'h00);
      pulse(0);
      `CHK(alarm, 1'b1)
      // A present condition restarts the run
      for (int i = 0; i < 6; i++) begin
        cond[c] <= (i == 2);
        pulse(c + 1);
        `CHK(alarm, i < 5)
      end
    end
    $display("Test done: remote alarm");
    bus(1'b1, idx_rc0, 8'h00);
    pulse(4);
    pulse(5);
    crc_chk(1'b0);
    bus(1'b1, idx_rc0, 8'h01);
    pulse(5);
    crc_chk(1'b0);
    pulse(4);
    crc_chk(1'b0);
    pulse(5);
    crc_chk(1'b1);
    crc_chk(1'b1);
    pulse(5);
    crc_chk(1'b0);
    bus(1'b1, idx_rc0, 8'h02);
    crc_chk(1'b1);
    bus(1'b1, idx_rc0, 8'h03);
    crc_chk(1'b1);
    $display("Test done: crc inversion");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, idx_rc0, {5'h0, m[0], 2'h0});
      bus(1'b1, idx_cfg, {4'h0, m[1], 3'h2});
      rnd = $random(seed);
      pins <= rnd[2:0];
      slow <= 1'b1;
      repeat (16) @(posedge clock_in);
      slow <= 1'b0;
      repeat (10) @(posedge clock_in);
      `CHK({rxv, rxd}, {1'b1, sense(m[1], m[0], rnd[2:0])})
    end
    hold <= 1'b1;
    repeat (12) @(posedge clock_in);
    bus(1'b0, idx_stat, 8'h00);
    `CHK(r[st_fifo:st_ovf], 2'h3)
    hold <= 1'b0;
    $display("Test done: receive sense and buffer");
    for (int t = 0; t < 3; t++) begin
      rnd = $random(seed);
      mp = t == 2 ? 2047 : (t == 1 ? int'(rnd[7:0]) % 193 : int'(rnd[10:0]));
      off = mp_off(t == 1, mp);
      bus(1'b1, idx_cfg, 8'h02);
      bus(1'b1, idx_offl, off[7:0]);
      bus(1'b1, idx_rc0, {1'b0, off[10:8], 4'h0});
      bus(1'b1, idx_cfg, {5'h0, pfc_marker});
      n = 0;
      while (marker !== 1'b1 && n < 2100) begin
        @(posedge clock_in);
        n++;
      end
      `CHK({marker, count}, {1'b1, off + 11'h1})
    end
    bus(1'b1, idx_cfg, {5'h0, pfc_sync});
    sync <= 1'b1;
    repeat (6) @(posedge clock_in);
    `CHK(count, off)
    sync <= 1'b0;
    $display("Test done: marker and sync load");
    rstn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    `CHK(wreq, 1'b1)
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    bus(1'b0, idx_rc0, 8'h00);
    `CHK(r, 32'h0)
    $display("Test done: second reset");
    report_and_stop();
  end
endmodule : t1_receive_control_and_pulse_mask_tb
